// [design/updown_wiper_host.v]
// Operation
// - host opens session, holds select low
// - direction set early, strobe left high
// - select rises before strobe: no save
// - strobe rises early before select: save
// - select pulse, strobe high: save only
`timescale 1ns/10ps
`include "updown_wiper_nv_store_regs.vh"

module updown_wiper_host (
  input  wire       clock,
  input  wire       resetn,
  input  wire       clock_enable,
  input  wire       cmd_valid,
  input  wire [1:0] cmd_op,
  input  wire       cmd_dir_up,
  input  wire [4:0] cmd_steps,
  output reg        cmd_ready,
  output reg        done,
  output reg  [4:0] pos_est,
  output reg        select_n,
  output reg        dir_up,
  output reg        strobe_n
);

  // ==========================================================
  // commands: 0 move without save, 1 move and save, 2 save only
  localparam OP_MOVE      = 2'h0;
  localparam OP_MOVE_SAVE = 2'h1;
  localparam OP_SAVE      = 2'h2;

  localparam S_WAKE   = 4'h0;
  localparam S_IDLE   = 4'h1;
  localparam S_SEL    = 4'h2;
  localparam S_FALL   = 4'h3;
  localparam S_LOW    = 4'h4;
  localparam S_HIGH   = 4'h5;
  localparam S_ENDRAW = 4'h6;
  localparam S_ENDSTB = 4'h7;
  localparam S_PULSE  = 4'h8;
  localparam S_STORE  = 4'h9;
  localparam S_GAP    = 4'hA;

  // ==========================================================
  // counter loads, one less than the wait where the load edge counts
  localparam [31:0] WAKE_LOAD   = `CONTROL_WAKE_CYC;
  localparam [31:0] PULSE_LOAD  = `SELECT_PULSE_WIDTH_CYC - 1;
  localparam [31:0] DIR_LOAD    = `DIR_SETUP_CYC - 1;
  localparam [31:0] IC_LOAD     = `STROBE_TO_DESELECT_CYC - 1;
  localparam [31:0] LOW_LOAD    = `STROBE_LOW_CYC - 1;
  localparam [31:0] HIGH_LOAD   = `STROBE_HIGH_CYC - 1;
  localparam [31:0] GAP_LOAD    = `DESELECT_CYC - 1;
  localparam [31:0] STORE_LOAD  = `STORE_CYC - 1;

  // ==========================================================
  // registers
  // shared down-counter for every pin wait
  reg [3:0]  state_reg;
  reg [23:0] count_reg;
  reg [4:0]  left_reg;
  reg        save_reg;

  wire       count_zero = (count_reg == 24'h000000);

  // ==========================================================
  // sequencer
  always @(posedge clock) begin
    if (!resetn) begin
      state_reg <= S_WAKE;
      count_reg <= WAKE_LOAD[23:0];
      left_reg  <= 5'h00;
      save_reg  <= 1'b0;
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      pos_est   <= 5'h00;
      select_n  <= 1'b1;
      dir_up    <= 1'b0;
      strobe_n  <= 1'b1;
    end else if (clock_enable) begin
      done <= 1'b0;
      if (!count_zero)
        count_reg <= count_reg - 24'h000001;
      case (state_reg)
        S_WAKE: begin
          // device loads its saved value inside this wait
          if (count_zero) begin
            state_reg <= S_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        S_IDLE: begin
          // op 3 is treated as a plain move
          if (cmd_valid) begin
            cmd_ready <= 1'b0;
            dir_up    <= cmd_dir_up;
            left_reg  <= cmd_steps;
            save_reg  <= (cmd_op == OP_MOVE_SAVE);
            select_n  <= 1'b0;
            if (cmd_op == OP_SAVE) begin
              state_reg <= S_PULSE;
              count_reg <= PULSE_LOAD[23:0];
            end else begin
              state_reg <= S_SEL;
              count_reg <= DIR_LOAD[23:0];
            end
          end
        end
        S_SEL: begin
          // zero steps ends as a plain save
          if (count_zero) begin
            if (left_reg == 5'h00) begin
              state_reg <= S_ENDSTB;
              count_reg <= IC_LOAD[23:0];
            end else
              state_reg <= S_FALL;
          end
        end
        S_FALL: begin
          // estimate follows the device, saturating at both ends
          strobe_n  <= 1'b0;
          left_reg  <= left_reg - 5'h01;
          if (dir_up && pos_est != `POS_MAX)
            pos_est <= pos_est + 5'h01;
          else if (!dir_up && pos_est != 5'h00)
            pos_est <= pos_est - 5'h01;
          state_reg <= S_LOW;
          count_reg <= LOW_LOAD[23:0];
        end
        S_LOW: begin
          // strobe rising first saves, select rising first does not
          if (count_zero) begin
            if (left_reg == 5'h00) begin
              if (save_reg) begin
                strobe_n  <= 1'b1;
                state_reg <= S_ENDSTB;
                count_reg <= IC_LOAD[23:0];
              end else begin
                select_n  <= 1'b1;
                state_reg <= S_ENDRAW;
                count_reg <= LOW_LOAD[23:0];
              end
            end else begin
              strobe_n  <= 1'b1;
              state_reg <= S_HIGH;
              count_reg <= HIGH_LOAD[23:0];
            end
          end
        end
        S_HIGH: begin
          // strobe high time before the next fall
          if (count_zero)
            state_reg <= S_FALL;
        end
        S_ENDRAW: begin
          // strobe rises only once select is already high
          if (count_zero) begin
            strobe_n  <= 1'b1;
            state_reg <= S_GAP;
            count_reg <= GAP_LOAD[23:0];
          end
        end
        S_ENDSTB: begin
          if (count_zero) begin
            select_n  <= 1'b1;
            state_reg <= S_STORE;
            count_reg <= STORE_LOAD[23:0];
          end
        end
        S_PULSE: begin
          // select pulse with strobe high, wiper stays put
          if (count_zero) begin
            select_n  <= 1'b1;
            state_reg <= S_STORE;
            count_reg <= STORE_LOAD[23:0];
          end
        end
        S_STORE: begin
          // device ignores the pins for the whole store time
          if (count_zero)
            state_reg <= S_GAP;
        end
        S_GAP: begin
          // deselect time before the next session
          if (count_zero) begin
            state_reg <= S_IDLE;
            cmd_ready <= 1'b1;
            done      <= 1'b1;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule // updown_wiper_host

// [design/updown_wiper_nv_store_regs.vh]
`ifndef UPDOWN_WIPER_NV_STORE_REGS_VH
`define UPDOWN_WIPER_NV_STORE_REGS_VH

// ==========================================================
// timing figures (ns) and cycle counts at 25 MHz
`define CLK_PERIOD_NS             40
`define POS_COUNT                 32
`define POS_MAX                   5'h1F
`define SELECT_SETUP_NS           50
`define DIR_SETUP_NS              100
`define STROBE_LOW_NS             50
`define STROBE_HIGH_NS            100
`define STROBE_TO_DESELECT_NS     500
`define DESELECT_NS               100
`define SELECT_PULSE_WIDTH_NS     100
`define STORE_TIME_NS             10000000
`define NV_LOAD_TIME_NS           500000
`define CONTROL_WAKE_TIME_NS      2000000
`define CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SELECT_SETUP_CYC          `CYC(`SELECT_SETUP_NS)
`define DIR_SETUP_CYC             `CYC(`DIR_SETUP_NS)
`define STROBE_LOW_CYC            `CYC(`STROBE_LOW_NS)
`define STROBE_HIGH_CYC           `CYC(`STROBE_HIGH_NS)
`define STROBE_TO_DESELECT_CYC    `CYC(`STROBE_TO_DESELECT_NS)
`define DESELECT_CYC              `CYC(`DESELECT_NS)
`define SELECT_PULSE_WIDTH_CYC    `CYC(`SELECT_PULSE_WIDTH_NS)
`define STORE_CYC                 `CYC(`STORE_TIME_NS)
`define CONTROL_WAKE_CYC          `CYC(`CONTROL_WAKE_TIME_NS)

`endif

// [verif/wiper_pin_sva.sv]
`timescale 1ns/10ps
// ==================
// pin timing checks
module wiper_pin_sva (
  input wire       clock,
  input wire       resetn,
  input wire       cmd_ready,
  input wire [4:0] pos_est,
  input wire       select_n,
  input wire       dir_up,
  input wire       strobe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_wake; $rose(resetn) |-> select_n && strobe_n && !cmd_ready; endproperty
  a_wake: assert property (p_wake) else $error("pins active at wake");
  property p_sel; $fell(strobe_n) |-> !select_n; endproperty
  a_sel: assert property (p_sel) else $error("strobe while deselected");
  property p_setup; $fell(strobe_n) |-> dir_up == $past(dir_up, 3); endproperty
  a_setup: assert property (p_setup) else $error("direction setup");
  property p_low; $fell(strobe_n) |=> !strobe_n; endproperty
  a_low: assert property (p_low) else $error("strobe low width");
  property p_high; $rose(strobe_n) && !select_n |=> strobe_n [*2]; endproperty
  a_high: assert property (p_high) else $error("strobe high width");
  property p_step; $fell(strobe_n) |-> pos_est == (($past(pos_est) == (dir_up ? 5'h1F : 5'h00)) ?
    $past(pos_est) : $past(pos_est) + (dir_up ? 5'h01 : 5'h1F)); endproperty
  a_step: assert property (p_step) else $error("position step");
  property p_nosave; $rose(select_n) && !strobe_n |-> ##2 strobe_n; endproperty
  a_nosave: assert property (p_nosave) else $error("abort order");
  property p_ic; $rose(select_n) && strobe_n |-> $past(strobe_n, 13) && !$past(select_n, 3); endproperty
  a_ic: assert property (p_ic) else $error("save timing");
endmodule // wiper_pin_sva
bind updown_wiper_host wiper_pin_sva chk (.clock(clock), .resetn(resetn), .cmd_ready(cmd_ready),
  .pos_est(pos_est), .select_n(select_n), .dir_up(dir_up), .strobe_n(strobe_n));

// [verif/wiper_dev.sv]
`timescale 1ns/10ps
// ============
// device model
module wiper_dev (
  input  wire       select_n,
  input  wire       dir_up,
  input  wire       strobe_n,
  output reg  [4:0] wiper,
  output reg  [4:0] saved
);
  reg armed;
  initial begin
    saved = 5'h00;
    wiper = saved;
    armed = 1'b0;
  end
  always @(negedge strobe_n)
    if (!select_n)
      wiper <= dir_up ? wiper + (wiper != 5'h1F) : wiper - (wiper != 5'h00);
  always @(negedge select_n) armed = 1'b1;
  always @(posedge select_n) begin
    if (armed && strobe_n) begin
      saved <= wiper;
      #10000000;
    end
    armed = 1'b0;
  end
endmodule // wiper_dev

// [verif/updown_wiper_nv_store_tb.sv]
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("unexpected %0t %h %h", $time, a, e); end end
// ===================
// host bench
module updown_wiper_nv_store_tb;
  reg        clock, resetn, cmd_valid, cmd_dir_up;
  reg  [1:0] cmd_op;
  reg  [4:0] cmd_steps, exp_pos, exp_saved, rs;
  wire       cmd_ready, done, select_n, dir_up, strobe_n;
  wire [4:0] pos_est, wiper, saved;
  reg  [9:0] q[$], e;
  integer    seed, fails, compares, i, n;
  updown_wiper_host dut (.clock(clock), .resetn(resetn), .clock_enable(1'b1), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_dir_up(cmd_dir_up), .cmd_steps(cmd_steps), .cmd_ready(cmd_ready), .done(done),
    .pos_est(pos_est), .select_n(select_n), .dir_up(dir_up), .strobe_n(strobe_n));
  wiper_dev dev (.select_n(select_n), .dir_up(dir_up), .strobe_n(strobe_n), .wiper(wiper), .saved(saved));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  task test_done; begin
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task run(input [1:0] op, input up, input [4:0] st); begin
    for (n = 0; n < 400000 && cmd_ready !== 1'b1; n++) begin @(posedge clock); #1; end
    if (n == 400000) begin fails++; test_done; end
    for (i = 0; i < st && op != 2'h2; i++)
      if (up) exp_pos = exp_pos + (exp_pos != 5'h1F);
      else exp_pos = exp_pos - (exp_pos != 5'h00);
    if (op == 2'h1 || op == 2'h2) exp_saved = exp_pos;
    q.push_back({exp_saved, exp_pos});
    cmd_op = op;
    cmd_dir_up = up;
    cmd_steps = st;
    cmd_valid = 1;
    @(posedge clock);
    #1 cmd_valid = 0;
  end endtask
  always @(posedge clock) if (done === 1'b1) begin
    e = q.pop_front();
    `CHK(pos_est, e[4:0])
    `CHK(wiper, e[4:0])
    `CHK(saved, e[9:5])
  end
  initial begin
    seed = 32'h3b05; fails = 0; compares = 0; exp_pos = 0; exp_saved = 0;
    resetn = 0; cmd_valid = 0; cmd_op = 0; cmd_dir_up = 0; cmd_steps = 0;
    repeat (10) @(posedge clock);
    #1 resetn = 1;
    run(2'h0, 1'b1, 5'h1F);
    run(2'h0, 1'b1, 5'h03);
    run(2'h2, 1'b0, 5'h00);
    run(2'h3, 1'b0, 5'h02);
    repeat (4) begin
      rs = $random(seed);
      run(2'h0, rs[4], rs | 5'h01);
    end
    run(2'h0, 1'b0, 5'h1F);
    run(2'h1, 1'b1, 5'h05);
    for (n = 0; n < 300000 && q.size() > 0; n++) @(posedge clock);
    if (n == 300000) fails++;
    test_done;
  end
endmodule // updown_wiper_nv_store_tb
